// *** common/pmic_params.svh ***
// How it works
// - Servicing any interrupt clears the master enable; later requests only set flags.
// - Software may set master and source enables again to nest interrupts.
// - No interrupt is acknowledged while the return stack is full.
// - Any pending enabled source raises the wake request from halt.
// - Acknowledge pushes only the program counter and branches to the vector.
// - Falling edge on the external pin sets the external flag.
// - External request calls vector 04H, clearing its flag and master enable.
// - Timer 0 overflow sets its flag; service calls 08H and clears it.
// - Timer 1 overflow sets its flag; service calls 0CH and clears it.
// - Clock tick sets the clock flag; service calls 14H and clears it.
// - Hook any edge, hold fall, handfree rise set dialer flag; vector 18H.
// - Hold falling edge is ignored while on-hook together with hold-line.
// - Dialer source is disabled while in Idle mode.
// - Further acknowledges wait for return or re-enabled master and source.
// - Return-from-interrupt sets master enable; plain return leaves it alone.
// - Requests are sampled and serviced at the next phase-two pulse.
// - Priority: external, timer 0, timer 1, clock, dialer; master masks all.
// - Low register: master bit 0, enables bits 1-3, flags bits 4-6, bit 7 zero.
// - High register: clock enable 1, dialer enable 2, flags 5 and 6; 3, 7 zero.
// - Software reads and writes flags, setting or clearing pending requests.
// - A flag stays set until serviced or cleared by software.
`ifndef PMIC_PARAMS_SVH
`define PMIC_PARAMS_SVH
`define PMIC_ADDR_LOW      8'h0B
`define PMIC_ADDR_HIGH     8'h1E
`define PMIC_BIT_MASTER    0
`define PMIC_BIT_EXT_EN    1
`define PMIC_BIT_T0_EN     2
`define PMIC_BIT_T1_EN     3
`define PMIC_BIT_EXT_FLG   4
`define PMIC_BIT_T0_FLG    5
`define PMIC_BIT_T1_FLG    6
`define PMIC_BIT_RSV0      0
`define PMIC_BIT_CLK_EN    1
`define PMIC_BIT_DIAL_EN   2
`define PMIC_BIT_RSV4      4
`define PMIC_BIT_CLK_FLG   5
`define PMIC_BIT_DIAL_FLG  6
`define PMIC_VEC_EXT       8'h04
`define PMIC_VEC_T0        8'h08
`define PMIC_VEC_T1        8'h0C
`define PMIC_VEC_CLK       8'h14
`define PMIC_VEC_DIAL      8'h18
`define PMIC_RESET_REG     8'h00
`endif

// *** common/pmic_pkg.sv ***
package pmic_pkg;
    typedef enum logic [2:0]
    {
        PMIC_SRC_NONE,
        PMIC_SRC_EXT,
        PMIC_SRC_T0,
        PMIC_SRC_T1,
        PMIC_SRC_CLK,
        PMIC_SRC_DIAL
    } pmic_src_t;
endpackage : pmic_pkg

// *** src/pmic_core.sv ***
// The strobed register port was decided locally.
`timescale 1ns/10ps
`include "pmic_params.svh"
module pmic_core
(
    input  wire logic       i_clock,
    input  wire logic       i_rst_b,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_ext_irq_pin,
    input  wire logic       i_tmr0_overflow,
    input  wire logic       i_tmr1_overflow,
    input  wire logic       i_clock_tick,
    input  wire logic       i_hook_switch_input,
    input  wire logic       i_hold_line_input,
    input  wire logic       i_handfree_input,
    input  wire logic       i_on_hook_hold_state,
    input  wire logic       i_idle_mode,
    input  wire logic       i_stack_full,
    input  wire logic       i_phase_two_pulse,
    input  wire logic       i_return_from_interrupt,
    input  wire logic       i_return_from_call,
    output logic            o_irq_ack,
    output logic      [7:0] o_irq_vector,
    output logic            o_push_pc,
    output logic            o_wake
);
    logic       master;
    logic [4:0] en;
    logic [4:0] flg;
    logic [1:0] rsv;
    logic       ext_q;
    logic       hook_q;
    logic       hold_q;
    logic       hf_q;
    logic [7:0] rdata;
    logic       ack;
    logic [7:0] vec;
    logic       wake;
    logic       next_master;
    logic [4:0] next_en;
    logic [4:0] next_flg;
    logic [1:0] next_rsv;
    logic [7:0] next_rdata;
    logic       next_ack;
    logic [7:0] next_vec;
    logic       next_wake;
    logic [4:0] hw_set;
    logic [4:0] pend;
    logic [4:0] grant;
    pmic_pkg::pmic_src_t src;
    logic       wr_low;
    logic       wr_high;

    assign wr_low  = i_wr && (i_addr == `PMIC_ADDR_LOW);
    assign wr_high = i_wr && (i_addr == `PMIC_ADDR_HIGH);

    always_comb
    begin
        hw_set[0] = ext_q && !i_ext_irq_pin;
        hw_set[1] = i_tmr0_overflow;
        hw_set[2] = i_tmr1_overflow;
        hw_set[3] = i_clock_tick;
        hw_set[4] = !i_idle_mode &&
                    ((hook_q != i_hook_switch_input) ||
                     (hold_q && !i_hold_line_input && !i_on_hook_hold_state) ||
                     (!hf_q && i_handfree_input));
        pend   = flg & en;
        if (i_idle_mode)
        begin
            pend[4] = 1'b0;
        end
        // Fixed priority, lowest index first
        grant = 5'h00;
        src   = pmic_pkg::PMIC_SRC_NONE;
        if (pend[0])
        begin
            grant[0] = 1'b1;
            src      = pmic_pkg::PMIC_SRC_EXT;
        end
        else if (pend[1])
        begin
            grant[1] = 1'b1;
            src      = pmic_pkg::PMIC_SRC_T0;
        end
        else if (pend[2])
        begin
            grant[2] = 1'b1;
            src      = pmic_pkg::PMIC_SRC_T1;
        end
        else if (pend[3])
        begin
            grant[3] = 1'b1;
            src      = pmic_pkg::PMIC_SRC_CLK;
        end
        else if (pend[4])
        begin
            grant[4] = 1'b1;
            src      = pmic_pkg::PMIC_SRC_DIAL;
        end
        // Acknowledge only on phase two, master set, stack has room
        if (!(i_phase_two_pulse && master && !i_stack_full))
        begin
            grant = 5'h00;
            src   = pmic_pkg::PMIC_SRC_NONE;
        end
    end

    always_comb
    begin
        next_master = master;
        next_en     = en;
        next_flg    = flg;
        next_rsv    = rsv;
        if (wr_low)
        begin
            next_master = i_wdata[`PMIC_BIT_MASTER];
            next_en[0]  = i_wdata[`PMIC_BIT_EXT_EN];
            next_en[1]  = i_wdata[`PMIC_BIT_T0_EN];
            next_en[2]  = i_wdata[`PMIC_BIT_T1_EN];
            next_flg[0] = i_wdata[`PMIC_BIT_EXT_FLG];
            next_flg[1] = i_wdata[`PMIC_BIT_T0_FLG];
            next_flg[2] = i_wdata[`PMIC_BIT_T1_FLG];
        end
        if (wr_high)
        begin
            next_rsv[0] = i_wdata[`PMIC_BIT_RSV0];
            next_rsv[1] = i_wdata[`PMIC_BIT_RSV4];
            next_en[3]  = i_wdata[`PMIC_BIT_CLK_EN];
            next_en[4]  = i_wdata[`PMIC_BIT_DIAL_EN];
            next_flg[3] = i_wdata[`PMIC_BIT_CLK_FLG];
            next_flg[4] = i_wdata[`PMIC_BIT_DIAL_FLG];
        end
        if (i_return_from_interrupt)
        begin
            next_master = 1'b1;
        end
        // Service clears master and the granted flag
        if (grant != 5'h00)
        begin
            next_master = 1'b0;
            next_flg    = next_flg & ~grant;
        end
        // A hardware event beats a clear in the same cycle
        next_flg = next_flg | hw_set;
    end

    always_comb
    begin
        next_rdata = 8'h00;
        if (i_rd && i_addr == `PMIC_ADDR_LOW)
        begin
            next_rdata[`PMIC_BIT_MASTER]  = master;
            next_rdata[`PMIC_BIT_EXT_EN]  = en[0];
            next_rdata[`PMIC_BIT_T0_EN]   = en[1];
            next_rdata[`PMIC_BIT_T1_EN]   = en[2];
            next_rdata[`PMIC_BIT_EXT_FLG] = flg[0];
            next_rdata[`PMIC_BIT_T0_FLG]  = flg[1];
            next_rdata[`PMIC_BIT_T1_FLG]  = flg[2];
        end
        else if (i_rd && i_addr == `PMIC_ADDR_HIGH)
        begin
            next_rdata[`PMIC_BIT_RSV0]     = rsv[0];
            next_rdata[`PMIC_BIT_CLK_EN]   = en[3];
            next_rdata[`PMIC_BIT_DIAL_EN]  = en[4];
            next_rdata[`PMIC_BIT_RSV4]     = rsv[1];
            next_rdata[`PMIC_BIT_CLK_FLG]  = flg[3];
            next_rdata[`PMIC_BIT_DIAL_FLG] = flg[4];
        end
        next_ack = (grant != 5'h00);
        case (src)
            pmic_pkg::PMIC_SRC_EXT:  next_vec = `PMIC_VEC_EXT;
            pmic_pkg::PMIC_SRC_T0:   next_vec = `PMIC_VEC_T0;
            pmic_pkg::PMIC_SRC_T1:   next_vec = `PMIC_VEC_T1;
            pmic_pkg::PMIC_SRC_CLK:  next_vec = `PMIC_VEC_CLK;
            pmic_pkg::PMIC_SRC_DIAL: next_vec = `PMIC_VEC_DIAL;
            default:                 next_vec = vec;
        endcase
        // Wake ignores master and stack so a halted core always resumes
        next_wake = (pend != 5'h00);
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            master  <= 1'b0;
            en      <= 5'h00;
            flg     <= 5'h00;
            rsv     <= 2'h0;
            ext_q   <= 1'b1;
            hook_q  <= 1'b0;
            hold_q  <= 1'b0;
            hf_q    <= 1'b0;
            rdata   <= `PMIC_RESET_REG;
            ack     <= 1'b0;
            vec     <= 8'h00;
            wake    <= 1'b0;
        end
        else
        begin
            master  <= next_master;
            en      <= next_en;
            flg     <= next_flg;
            rsv     <= next_rsv;
            ext_q   <= i_ext_irq_pin;
            hook_q  <= i_hook_switch_input;
            hold_q  <= i_hold_line_input;
            hf_q    <= i_handfree_input;
            rdata   <= next_rdata;
            ack     <= next_ack;
            vec     <= next_vec;
            wake    <= next_wake;
        end
    end

    assign o_rdata      = rdata;
    assign o_irq_ack    = ack;
    assign o_push_pc    = ack;
    assign o_irq_vector = vec;
    assign o_wake       = wake;
endmodule : pmic_core

// *** test/pmic_core_asserts.sv ***
`timescale 1ns/10ps
module pmic_core_asserts
(
    input wire logic       i_clock,
    input wire logic       i_rst_b,
    input wire logic [7:0] i_addr,
    input wire logic       i_rd,
    input wire logic       i_stack_full,
    input wire logic       i_phase_two_pulse,
    input wire logic [7:0] o_rdata,
    input wire logic       o_irq_ack,
    input wire logic [7:0] o_irq_vector,
    input wire logic       o_push_pc
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);
    chk_ack_on_phase: assert property (o_irq_ack |-> $past(i_phase_two_pulse))
        else $error("ack without phase pulse");
    chk_no_ack_full: assert property (o_irq_ack |-> !$past(i_stack_full))
        else $error("ack while stack full");
    chk_push_with_ack: assert property (o_push_pc == o_irq_ack)
        else $error("push and ack differ");
    chk_ack_single: assert property (o_irq_ack |=> !o_irq_ack)
        else $error("ack longer than one cycle");
    chk_vector_legal: assert property (o_irq_ack |-> o_irq_vector inside {8'h04, 8'h08, 8'h0C, 8'h14, 8'h18})
        else $error("illegal vector");
    chk_vector_holds: assert property (!o_irq_ack |-> $stable(o_irq_vector))
        else $error("vector changed without ack");
    chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    chk_unused_bits: assert property ($past(i_rd) |-> !o_rdata[7] && !($past(i_addr) == 8'h1E && o_rdata[3]))
        else $error("unused bit reads one");
    chk_unmapped_zero: assert property ($past(i_rd) && !($past(i_addr) inside {8'h0B, 8'h1E}) |-> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    cover property (o_irq_ack && o_irq_vector == 8'h04);
    cover property (o_irq_ack && o_irq_vector == 8'h18);
    cover property (i_stack_full && i_phase_two_pulse);
endmodule : pmic_core_asserts
bind pmic_core pmic_core_asserts chk_u (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_rd(i_rd),
    .i_stack_full(i_stack_full), .i_phase_two_pulse(i_phase_two_pulse), .o_rdata(o_rdata),
    .o_irq_ack(o_irq_ack), .o_irq_vector(o_irq_vector), .o_push_pc(o_push_pc));

// *** test/pmic_seq_model.sv ***
`timescale 1ns/10ps
module pmic_seq_model
#(
    parameter int DEPTH = 2
)
(
    input  wire logic i_clock,
    input  wire logic i_rst_b,
    input  wire logic i_push_pc,
    input  wire logic i_pop,
    output logic      o_phase_two_pulse,
    output logic      o_stack_full
);
    logic [1:0] phase;
    logic [3:0] level;
    // Only interrupt pushes are counted, so a small depth reaches full quickly
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
            {phase, level} <= 6'h00;
        else
            {phase, level} <= {phase + 2'h1, level + {3'h0, i_push_pc} - {3'h0, i_pop}};
    end
    assign o_phase_two_pulse = (phase == 2'h3);
    assign o_stack_full      = (level == DEPTH[3:0]);
endmodule : pmic_seq_model

// *** test/phone_mcu_interrupt_control_tb.sv ***
`timescale 1ns/10ps
`include "pmic_params.svh"
module phone_mcu_interrupt_control_tb;
    logic       clk, rst_b, wr_en, rd_en, ext, t0, t1, tick, hook, hold, hf, onh, idle, return_from_interrupt, retc;
    logic [7:0] addr, wdata;
    wire  [7:0] rdata, vec;
    wire        ack, push, wake, phase, full;
    int         mismatches = 0;
    int         comparisons = 0;
    logic [7:0] ev_addr [10] = '{8'h0B, 8'h0B, 8'h1E, 8'h0B, 8'h1E, 8'h1E, 8'h1E, 8'h1E, 8'h1E, 8'h1E};
    logic [7:0] ev_exp [10]  = '{8'h20, 8'h40, 8'h20, 8'h10, 8'h40, 8'h40, 8'h40, 8'h40, 8'h00, 8'h00};
    logic [7:0] vecs [5]     = '{`PMIC_VEC_EXT, `PMIC_VEC_T0, `PMIC_VEC_T1, `PMIC_VEC_CLK, `PMIC_VEC_DIAL};
    pmic_core dut_u (.i_clock(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_en), .i_rd(rd_en),
        .o_rdata(rdata), .i_ext_irq_pin(ext), .i_tmr0_overflow(t0), .i_tmr1_overflow(t1), .i_clock_tick(tick),
        .i_hook_switch_input(hook), .i_hold_line_input(hold), .i_handfree_input(hf), .i_on_hook_hold_state(onh),
        .i_idle_mode(idle), .i_stack_full(full), .i_phase_two_pulse(phase), .i_return_from_interrupt(return_from_interrupt),
        .i_return_from_call(retc), .o_irq_ack(ack), .o_irq_vector(vec), .o_push_pc(push), .o_wake(wake));
    pmic_seq_model #(.DEPTH(2)) seq_u (.i_clock(clk), .i_rst_b(rst_b), .i_push_pc(push), .i_pop(return_from_interrupt | retc),
        .o_phase_two_pulse(phase), .o_stack_full(full));
    always #10 clk = ~clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {addr, wdata, wr_en} <= {a, d, 1'b1};
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        {addr, rd_en} <= {a, 1'b1};
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk(rdata, e);
    endtask : reg_rd
    task automatic ret(input logic from_irq);
        @(posedge clk);
        {return_from_interrupt, retc} <= {from_irq, !from_irq};
        @(posedge clk);
        {return_from_interrupt, retc} <= 2'b00;
    endtask : ret
    // Bounded wait; with want low it spans four phase pulses to prove no grant
    task automatic wait_ack(input logic want, input logic [7:0] e);
        logic got;
        got = 1'b0;
        for (int k = 0; k < 16 && !got; k++)
        begin
            @(posedge clk);
            #1 got = (ack === 1'b1);
        end
        chk({7'h0, got}, {7'h0, want});
        if (got)
            chk(vec, e);
        // A missing grant leaves the stack model out of step, so stop here
        if (want && !got)
            complete_run();
    endtask : wait_ack
    task automatic ev(input int n);
        @(posedge clk);
        {onh, idle} <= {n == 8, n == 9};
        case (n)
            0: t0 <= 1'b1;
            1: t1 <= 1'b1;
            2: tick <= 1'b1;
            3: ext <= 1'b0;
            4, 9: hook <= 1'b1;
            5: hook <= 1'b0;
            6, 8: hold <= 1'b0;
            default: hf <= 1'b1;
        endcase
        @(posedge clk);
        {t0, t1, tick, ext, hold, hf} <= 6'b000110;
        if (n == 9)
            hook <= 1'b0;
        @(posedge clk);
        {onh, idle} <= 2'b00;
        reg_rd(ev_addr[n], ev_exp[n]);
        reg_wr(ev_addr[n], 8'h00);
    endtask : ev
    task automatic complete_run;
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    initial
    begin
        {clk, rst_b, wr_en, rd_en, t0, t1, tick, hook, hf, onh, idle, return_from_interrupt, retc} = '0;
        {ext, hold, addr, wdata} = {2'b11, 16'h0000};
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        reg_rd(`PMIC_ADDR_LOW, 8'h00);
        reg_rd(`PMIC_ADDR_HIGH, 8'h00);
        $display("reset test done");
        reg_wr(`PMIC_ADDR_LOW, 8'hFE);
        reg_wr(`PMIC_ADDR_HIGH, 8'hFF);
        reg_wr(8'h0C, 8'hFF);
        reg_rd(`PMIC_ADDR_LOW, 8'h7E);
        reg_rd(`PMIC_ADDR_HIGH, 8'h77);
        reg_rd(8'h0C, 8'h00);
        chk({7'h0, wake}, 8'h01);
        wait_ack(1'b0, 8'h00);
        reg_wr(`PMIC_ADDR_LOW, 8'h00);
        reg_wr(`PMIC_ADDR_HIGH, 8'h00);
        $display("layout test done");
        for (int n = 0; n < 10; n++)
            ev(n);
        $display("event test done");
        reg_wr(`PMIC_ADDR_HIGH, 8'h66);
        reg_wr(`PMIC_ADDR_LOW, 8'h7F);
        for (int i = 0; i < 5; i++)
        begin
            wait_ack(1'b1, vecs[i]);
            if (i == 0)
                reg_rd(`PMIC_ADDR_LOW, 8'h6E);
            ret(1'b1);
        end
        reg_rd(`PMIC_ADDR_HIGH, 8'h06);
        reg_wr(`PMIC_ADDR_HIGH, 8'h00);
        $display("priority test done");
        reg_wr(`PMIC_ADDR_LOW, 8'h13);
        wait_ack(1'b1, `PMIC_VEC_EXT);
        reg_wr(`PMIC_ADDR_LOW, 8'h13);
        wait_ack(1'b1, `PMIC_VEC_EXT);
        reg_wr(`PMIC_ADDR_LOW, 8'h13);
        wait_ack(1'b0, 8'h00);
        ret(1'b0);
        wait_ack(1'b1, `PMIC_VEC_EXT);
        reg_rd(`PMIC_ADDR_LOW, 8'h02);
        $display("stack test done");
        complete_run();
    end
endmodule : phone_mcu_interrupt_control_tb
